// ===== fkar_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "fkar_params.svh"
module fkar_chk
   import fkar_pkg::*;
(
   // clock and reset
   input wire logic            clk_i,
   input wire logic            rst_n_i,
   // watched ports
   input wire fkar_bus_req_t   bus_i,
   input wire logic [31:0]     rd_data_o,
   input wire fkar_flash_cmd_t flash_cmd_o,
   input wire logic            flash_done_i,
   input wire logic            busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic        st = flash_cmd_o.start;
   wire logic [1:0]  op = flash_cmd_o.op;
   wire logic [31:0] fa = flash_cmd_o.addr;
   wire logic        wk = bus_i.wr && bus_i.addr == `FKAR_OFS_KEY;
   wire logic        go = bus_i.wr && bus_i.addr == `FKAR_OFS_CTRL && bus_i.wdata[`FKAR_CTRL_START];
   property p_key_rd; bus_i.rd && bus_i.addr == `FKAR_OFS_KEY |=> rd_data_o == 32'h0; endproperty
   a_key_rd: assert property (p_key_rd) else $error("key read not zero");
   property p_seq;
      wk && bus_i.wdata == `FKAR_KEY_FIRST ##1 wk && bus_i.wdata == `FKAR_KEY_SECOND ##1 go && !busy_o |=> st;
   endproperty
   a_seq: assert property (p_seq) else $error("unlock did not start");
   property p_tgt; bus_i.wr && bus_i.addr == `FKAR_OFS_TARGET ##1 bus_i.rd && bus_i.addr == `FKAR_OFS_TARGET
      |=> rd_data_o == $past(bus_i.wdata, 2); endproperty
   a_tgt: assert property (p_tgt) else $error("target readback wrong");
   property p_bulk; st && op == FKAR_OP_BULK |-> fa == 32'h0; endproperty
   a_bulk: assert property (p_bulk) else $error("bulk address not ignored");
   property p_page; st && op == FKAR_OP_PAGE |-> fa[11:0] == 12'h000; endproperty
   a_page: assert property (p_page) else $error("page address unaligned");
   property p_row; st && op == FKAR_OP_ROW |-> fa[8:0] == 9'h000; endproperty
   a_row: assert property (p_row) else $error("row address unaligned");
   property p_word; st && op == FKAR_OP_WORD |-> fa[1:0] == 2'h0; endproperty
   a_word: assert property (p_word) else $error("word address unaligned");
   property p_cause; st |-> $past(go) && !$past(busy_o); endproperty
   a_cause: assert property (p_cause) else $error("start without control write");
   c_start: cover property (st ##1 flash_done_i);
   c_bulk: cover property (st && op == FKAR_OP_BULK);
   c_key: cover property (wk ##1 bus_i.rd);
endmodule : fkar_chk
bind fkar_top fkar_chk fkar_chk_inst (.clk_i, .rst_n_i, .bus_i, .rd_data_o, .flash_cmd_o, .flash_done_i, .busy_o);
`default_nettype wire

// ===== fkar_params.svh
// Functional notes
// - The unlock key register is 32 bits, write-only, and every read of it returns all zeros.
// - Software writes the key register as one step of an unlock sequence that blocks accidental flash writes.
// - The target address register is 32 bits, readable and writable, and resets to zero.
// - A bulk erase ignores the target address register.
// - A page erase uses the target address register to select the page.
// - A row program uses the target address register to select the row.
// - A word program uses the target address register to select the word.
`ifndef FKAR_PARAMS_SVH
`define FKAR_PARAMS_SVH

`define FKAR_ADDR_W        8
`define FKAR_OFS_KEY       8'h00
`define FKAR_OFS_TARGET    8'h04
`define FKAR_OFS_CTRL      8'h08
`define FKAR_OFS_STATUS    8'h0C
`define FKAR_RST_WORD      32'h0000_0000
`define FKAR_CTRL_OP_LSB   0
`define FKAR_CTRL_OP_MSB   1
`define FKAR_CTRL_START    15
`define FKAR_STAT_ERR      0
`define FKAR_STAT_BUSY     1
`define FKAR_STAT_UNLOCKED 2
`define FKAR_KEY_FIRST     32'h1234_5678
`define FKAR_KEY_SECOND    32'h8765_4321
`define FKAR_PAGE_BYTES    32'h0000_1000
`define FKAR_ROW_BYTES     32'h0000_0200
`define FKAR_WORD_BYTES    32'h0000_0004

`endif

// ===== fkar_pkg.sv
package fkar_pkg;

   typedef enum logic [1:0] {FKAR_OP_WORD, FKAR_OP_ROW, FKAR_OP_PAGE, FKAR_OP_BULK} fkar_op_t;

   typedef enum logic [1:0] {FKAR_LOCKED, FKAR_KEY1_SEEN, FKAR_UNLOCKED} fkar_lock_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fkar_bus_req_t;

   typedef struct packed {
      logic        start;
      fkar_op_t    op;
      logic [31:0] addr;
   } fkar_flash_cmd_t;

   typedef struct packed {
      fkar_lock_t      lock;
      logic [31:0]     target;
      fkar_op_t        op_sel;
      logic            busy;
      logic            err;
      logic [31:0]     rdata;
      fkar_flash_cmd_t cmd;
   } fkar_state_t;

endpackage : fkar_pkg

// ===== fkar_top.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fkar_params.svh"

module fkar_top (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   // register port
   input  wire fkar_pkg::fkar_bus_req_t  bus_i,
   output logic [31:0]                   rd_data_o,
   // flash engine
   output fkar_pkg::fkar_flash_cmd_t     flash_cmd_o,
   input  wire logic                     flash_done_i,
   output logic                          busy_o
);
   import fkar_pkg::*;

   fkar_state_t st_r;
   fkar_state_t st_nxt;

   // clear the low bits below the unit size
   function automatic logic [31:0] align_addr(input logic [31:0] a, input logic [31:0] unit);
      align_addr = a & ~(unit - 32'h0000_0001);
   endfunction : align_addr

   function automatic logic [31:0] target_for(input fkar_op_t op, input logic [31:0] a);
      case (op)
         FKAR_OP_BULK: target_for = `FKAR_RST_WORD;
         FKAR_OP_PAGE: target_for = align_addr(a, `FKAR_PAGE_BYTES);
         FKAR_OP_ROW:  target_for = align_addr(a, `FKAR_ROW_BYTES);
         FKAR_OP_WORD: target_for = align_addr(a, `FKAR_WORD_BYTES);
         default:      target_for = `FKAR_RST_WORD;
      endcase
   endfunction : target_for

   logic     acc;
   logic     start_req;
   fkar_op_t wr_op;

   always_comb
   begin
      acc       = bus_i.wr | bus_i.rd;
      wr_op     = fkar_op_t'(bus_i.wdata[`FKAR_CTRL_OP_MSB:`FKAR_CTRL_OP_LSB]);
      start_req = bus_i.wr && (bus_i.addr == `FKAR_OFS_CTRL) && bus_i.wdata[`FKAR_CTRL_START];
      st_nxt           = st_r;
      st_nxt.cmd.start = 1'b0;
      st_nxt.rdata     = `FKAR_RST_WORD;

      if (flash_done_i)
         st_nxt.busy = 1'b0;

      // unlock sequence; every access advances or drops it
      if (acc)
      begin
         case (st_r.lock)
            FKAR_LOCKED:
               st_nxt.lock = (bus_i.wr && bus_i.addr == `FKAR_OFS_KEY && bus_i.wdata == `FKAR_KEY_FIRST)
                             ? FKAR_KEY1_SEEN : FKAR_LOCKED;
            FKAR_KEY1_SEEN:
               st_nxt.lock = (bus_i.wr && bus_i.addr == `FKAR_OFS_KEY && bus_i.wdata == `FKAR_KEY_SECOND)
                             ? FKAR_UNLOCKED : FKAR_LOCKED;
            FKAR_UNLOCKED:
               st_nxt.lock = FKAR_LOCKED;
            default:
               st_nxt.lock = FKAR_LOCKED;
         endcase
      end

      if (bus_i.wr)
      begin
         case (bus_i.addr)
            `FKAR_OFS_TARGET: st_nxt.target = bus_i.wdata;
            `FKAR_OFS_CTRL:
            begin
               st_nxt.op_sel = wr_op;
               if (start_req)
               begin
                  // a start that skipped the keys or hit a busy engine is refused and flagged
                  if (st_r.lock == FKAR_UNLOCKED && !st_r.busy)
                  begin
                     st_nxt.cmd.start = 1'b1;
                     st_nxt.cmd.op    = wr_op;
                     st_nxt.cmd.addr  = target_for(wr_op, st_r.target);
                     st_nxt.busy      = 1'b1;
                  end
                  else
                     st_nxt.err = 1'b1;
               end
            end
            `FKAR_OFS_STATUS:
               if (bus_i.wdata[`FKAR_STAT_ERR] && !(start_req))
                  st_nxt.err = 1'b0;
            default: ;
         endcase
      end

      if (bus_i.rd)
      begin
         case (bus_i.addr)
            `FKAR_OFS_KEY:    st_nxt.rdata = `FKAR_RST_WORD;
            `FKAR_OFS_TARGET: st_nxt.rdata = st_r.target;
            `FKAR_OFS_CTRL:   st_nxt.rdata[`FKAR_CTRL_OP_MSB:`FKAR_CTRL_OP_LSB] = st_r.op_sel;
            `FKAR_OFS_STATUS:
            begin
               st_nxt.rdata[`FKAR_STAT_ERR]      = st_r.err;
               st_nxt.rdata[`FKAR_STAT_BUSY]     = st_r.busy;
               st_nxt.rdata[`FKAR_STAT_UNLOCKED] = (st_r.lock == FKAR_UNLOCKED);
            end
            default:          st_nxt.rdata = `FKAR_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_r.lock      <= FKAR_LOCKED;
         st_r.target    <= `FKAR_RST_WORD;
         st_r.op_sel    <= FKAR_OP_WORD;
         st_r.busy      <= 1'b0;
         st_r.err       <= 1'b0;
         st_r.rdata     <= `FKAR_RST_WORD;
         st_r.cmd.start <= 1'b0;
         st_r.cmd.op    <= FKAR_OP_WORD;
         st_r.cmd.addr  <= `FKAR_RST_WORD;
      end
      else
         st_r <= st_nxt;
   end

   assign rd_data_o   = st_r.rdata;
   assign flash_cmd_o = st_r.cmd;
   assign busy_o      = st_r.busy;

endmodule : fkar_top
`default_nettype wire

// ===== flash_key_and_address_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fkar_params.svh"
module flash_key_and_address_regs_tb_top;
   import fkar_pkg::*;
   logic            clk_i = 1'b0;
   logic            rst_n_i = 1'b0;
   logic            done = 1'b0;
   logic            busy;
   logic [31:0]     rdat;
   fkar_bus_req_t   b = '0;
   fkar_flash_cmd_t cmd;
   int              error_cnt = 0;
   int              num_checks = 0;
   int              cyc = 0;
   logic [31:0]     msk [4] = '{32'hFFFF_FFFC, 32'hFFFF_FE00, 32'hFFFF_F000, 32'h0};
   always #25 clk_i = ~clk_i;
   fkar_top fkar_top_inst (.clk_i, .rst_n_i, .bus_i(b), .rd_data_o(rdat), .flash_cmd_o(cmd),
      .flash_done_i(done), .busy_o(busy));
   task acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
      b <= {a, d, w, r};
      @(posedge clk_i);
      #1;
   endtask : acc
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   // runaway guard, tests need well under 100 cycles
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 500)
      begin
         error_cnt++;
         test_done;
      end
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      acc(0, 1, `FKAR_OFS_TARGET, 0);
      chk(rdat, 32'h0);
      acc(1, 0, `FKAR_OFS_KEY, 32'hFFFF_FFFF);
      acc(0, 1, `FKAR_OFS_KEY, 0);
      chk(rdat, 32'h0);
      acc(1, 0, `FKAR_OFS_TARGET, 32'hABCD_EFFF);
      acc(0, 1, `FKAR_OFS_TARGET, 0);
      chk(rdat, 32'hABCD_EFFF);
      for (int i = 0; i < 4; i++)
      begin
         acc(1, 0, `FKAR_OFS_KEY, `FKAR_KEY_FIRST);
         acc(1, 0, `FKAR_OFS_KEY, `FKAR_KEY_SECOND);
         acc(1, 0, `FKAR_OFS_CTRL, 32'h8000 | i);
         chk(32'(cmd.start), 32'h1);
         chk(32'(cmd.op), i);
         chk(cmd.addr, 32'hABCD_EFFF & msk[i]);
         done <= 1'b1;
         acc(0, 0, 0, 0);
         done <= 1'b0;
         chk(32'(busy), 32'h0);
      end
      // a read between the keys must break the sequence
      acc(1, 0, `FKAR_OFS_KEY, `FKAR_KEY_FIRST);
      acc(0, 1, `FKAR_OFS_KEY, 0);
      acc(1, 0, `FKAR_OFS_KEY, `FKAR_KEY_SECOND);
      acc(1, 0, `FKAR_OFS_CTRL, 32'h8002);
      chk(32'(cmd.start), 32'h0);
      acc(0, 1, `FKAR_OFS_STATUS, 0);
      chk(rdat, 32'h0000_0001);
      acc(0, 0, 0, 0);
      chk(rdat, 32'h0000_0000);
      acc(0, 1, `FKAR_OFS_CTRL, 0);
      chk(rdat, 32'h0000_0002);
      acc(1, 0, `FKAR_OFS_STATUS, 32'h0000_0001);
      acc(0, 1, `FKAR_OFS_STATUS, 0);
      chk(rdat, 32'h0000_0000);
      acc(0, 0, 0, 0);
      test_done;
   end
endmodule : flash_key_and_address_regs_tb_top
`default_nettype wire
